// ### core/adfm_monitor.sv
// FIFO tracking, DMA/link position and wall clock alias registers behind APB
`timescale 1ns/1ps
`include "adfm_map.svh"

module adfm_monitor (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [15:0]                paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire adfm_pkg::adfm_eng_t [3:0]  eng,
    input  wire logic [3:0][31:0]           cbl,
    input  wire logic [7:0]                 ring_rd_ptr,
    output logic                            ring_ptr_reset,
    output logic                            bclk_enable,
    input  wire logic                       link_bclk,
    input  wire logic [3:0]                 link_byte
);
    import adfm_pkg::*;

    adfm_pstate_t p_q;
    adfm_pstate_t p_d;
    adfm_lstate_t l_q;
    adfm_lstate_t l_d;

    logic          sel_ok;
    adfm_eng_idx_t sel_idx;
    logic [8:0]    sel_lvl;
    logic          sel_err;
    logic          wr_acc;
    logic          hs_done;
    logic          hit;
    logic [31:0]   rd_val;

    // Engine select decode; reserved codes leave sel_ok low
    always_comb
    begin
        sel_ok = (p_q.sel == `ADFM_SEL_OUT0) || (p_q.sel == `ADFM_SEL_OUT1) ||
                 (p_q.sel == `ADFM_SEL_IN0) || (p_q.sel == `ADFM_SEL_IN1);
        sel_idx = adfm_eng_idx_t'({p_q.sel[2], p_q.sel[0]});
        sel_lvl = eng[sel_idx].level;
        sel_err = eng[sel_idx].err;
    end

    // Write lands only at the edge where the access phase completes
    assign wr_acc  = psel && penable && p_q.pready && pwrite;
    // Link side has answered the last request: its hold words are stable
    assign hs_done = (p_q.ack_s2 == p_q.req);

    // Read decode, computed in the setup phase and registered for access
    always_comb
    begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            `ADFM_FIFO_TRACKING_OFS:
            begin
                rd_val[`ADFM_MIN_HI:`ADFM_MIN_LO] = p_q.min_lvl;
                rd_val[`ADFM_ERR_HI:`ADFM_ERR_LO] = p_q.err_cnt;
                rd_val[`ADFM_SEL_HI:`ADFM_SEL_LO] = p_q.sel;
                rd_val[`ADFM_EN_BIT]              = p_q.en;
                rd_val[`ADFM_RST_BIT]             = p_q.trk_rst;
            end
            `ADFM_IN0_DMA_POS_OFS:   rd_val = p_q.dma_pos[ADFM_ENG_IN0];
            `ADFM_IN1_DMA_POS_OFS:   rd_val = p_q.dma_pos[ADFM_ENG_IN1];
            `ADFM_OUT0_DMA_POS_OFS:  rd_val = p_q.dma_pos[ADFM_ENG_OUT0];
            `ADFM_OUTB_DMA_POS_OFS:  rd_val = p_q.dma_pos[ADFM_ENG_OUT1];
            `ADFM_EXT_MODE_TWO_OFS:  rd_val[`ADFM_RP_DIS_BIT] = p_q.rp_dis;
            `ADFM_RING_POINTER_OFS:
            begin
                rd_val[`ADFM_RPR_BIT] = p_q.rpr && !p_q.rp_dis;
                rd_val[7:0]           = ring_rd_ptr;
            end
            `ADFM_LINK_CTRL_OFS:     rd_val[`ADFM_BCLK_EN_BIT] = p_q.bclk_en;
            `ADFM_WALL_CLOCK_OFS:    rd_val = p_q.wclk;
            `ADFM_IN0_LINK_POS_OFS:  rd_val = p_q.lpos[ADFM_ENG_IN0];
            `ADFM_IN1_LINK_POS_OFS:  rd_val = p_q.lpos[ADFM_ENG_IN1];
            `ADFM_OUT0_LINK_POS_OFS: rd_val = p_q.lpos[ADFM_ENG_OUT0];
            `ADFM_OUTB_LINK_POS_OFS: rd_val = p_q.lpos[ADFM_ENG_OUT1];
            default:                 hit = 1'b0;
        endcase
    end

    // Next state of the pclk domain
    always_comb
    begin
        p_d = p_q;
        // APB: zero-wait answer, ready raised for exactly the access cycle
        p_d.pready  = psel && !penable;
        p_d.pslverr = psel && !penable && !hit;
        if (psel && !penable && !pwrite)
        begin
            p_d.prdata = rd_val;
        end
        // Register writes; each field follows its own byte lane
        if (wr_acc && hit)
        begin
            case (paddr)
                `ADFM_FIFO_TRACKING_OFS:
                begin
                    if (pstrb[0])
                    begin
                        p_d.sel     = pwdata[`ADFM_SEL_HI:`ADFM_SEL_LO];
                        p_d.en      = pwdata[`ADFM_EN_BIT];
                        p_d.trk_rst = pwdata[`ADFM_RST_BIT];
                    end
                end
                `ADFM_EXT_MODE_TWO_OFS:
                begin
                    if (pstrb[1])
                    begin
                        p_d.rp_dis = pwdata[`ADFM_RP_DIS_BIT];
                        if (pwdata[`ADFM_RP_DIS_BIT])
                        begin
                            p_d.rpr = 1'b0;
                        end
                    end
                end
                `ADFM_RING_POINTER_OFS:
                begin
                    // Disabled: the bit ignores writes, reads as zero and never reaches the ring
                    if (pstrb[1] && !p_q.rp_dis)
                    begin
                        p_d.rpr = pwdata[`ADFM_RPR_BIT];
                    end
                end
                `ADFM_LINK_CTRL_OFS:
                begin
                    if (pstrb[0])
                    begin
                        p_d.bclk_en = pwdata[`ADFM_BCLK_EN_BIT];
                    end
                end
                default:
                begin
                end
            endcase
        end
        // Tracking of the selected FIFO; reset outranks enable
        if (p_q.trk_rst)
        begin
            p_d.min_lvl = `ADFM_MIN_DEFAULT;
            p_d.err_cnt = 6'h00;
        end
        else if (p_q.en && sel_ok)
        begin
            if (sel_lvl < p_q.min_lvl)
            begin
                p_d.min_lvl = sel_lvl;
            end
            if (sel_err && (p_q.err_cnt != `ADFM_ERR_MAX))
            begin
                p_d.err_cnt = p_q.err_cnt + 6'h01;
            end
        end
        // DMA byte positions; output engines report at FIFO load time
        for (int i = 0; i < 4; i++)
        begin
            if (eng[i].bdl_start)
            begin
                p_d.dma_pos[i] = 32'h0000_0000;
            end
            else if (eng[i].load)
            begin
                p_d.dma_pos[i] = p_q.dma_pos[i] + {24'h00_0000, eng[i].load_bytes};
            end
        end
        // Handshake: take the link snapshot, refresh lengths, ask again
        p_d.ack_s1 = l_q.ack;
        p_d.ack_s2 = p_q.ack_s1;
        if (hs_done)
        begin
            p_d.wclk     = l_q.hold_wclk;
            p_d.lpos     = l_q.hold_lpos;
            p_d.cbl_hold = cbl;
            p_d.req      = !p_q.req;
        end
    end

    // Next state of the link domain
    always_comb
    begin
        l_d = l_q;
        l_d.en_s1  = p_q.bclk_en;
        l_d.en_s2  = l_q.en_s1;
        l_d.req_s1 = p_q.req;
        l_d.req_s2 = l_q.req_s1;
        // Counts every bit clock period while enabled; wraps by width
        if (l_q.en_s2)
        begin
            l_d.wclk = l_q.wclk + 32'h0000_0001;
        end
        // Wrap uses the latched length, never the pclk copy that may be changing
        for (int i = 0; i < 4; i++)
        begin
            if (link_byte[i])
            begin
                if ((l_q.lpos[i] + 32'h0000_0001) >= l_q.cbl[i])
                begin
                    l_d.lpos[i] = 32'h0000_0000;
                end
                else
                begin
                    l_d.lpos[i] = l_q.lpos[i] + 32'h0000_0001;
                end
            end
        end
        // New request: freeze a coherent copy for pclk and answer
        if (l_q.req_s2 != l_q.ack)
        begin
            l_d.hold_wclk = l_q.wclk;
            l_d.hold_lpos = l_q.lpos;
            l_d.cbl       = p_q.cbl_hold; // Settled: it changed with req two edges ago
            l_d.ack       = l_q.req_s2;
        end
    end

    // Controller-domain registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            p_q <= '0;
            p_q.min_lvl <= `ADFM_MIN_DEFAULT;
        end
        else
        begin
            p_q <= p_d;
        end
    end

    // Link-domain registers; controller reset also clears the wall clock
    always_ff @(posedge link_bclk or negedge presetn)
    begin
        if (!presetn)
        begin
            l_q <= '0;
        end
        else
        begin
            l_q <= l_d;
        end
    end

    // Outputs straight from flops
    assign prdata         = p_q.prdata;
    assign pready         = p_q.pready;
    assign pslverr        = p_q.pslverr;
    assign ring_ptr_reset = p_q.rpr;
    assign bclk_enable    = p_q.bclk_en;

    // Checks
    err_saturate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (p_q.err_cnt == `ADFM_ERR_MAX) && !p_q.trk_rst |=> (p_q.err_cnt == `ADFM_ERR_MAX))
        else $error("error count left its maximum without reset");

    trk_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        p_q.trk_rst |=> (p_q.min_lvl == `ADFM_MIN_DEFAULT) && (p_q.err_cnt == 6'h00))
        else $error("tracking reset did not restore defaults");

    trk_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !p_q.en && !p_q.trk_rst |=> $stable(p_q.min_lvl) && $stable(p_q.err_cnt))
        else $error("tracking fields moved while disabled");

    reserved_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sel_ok && !p_q.trk_rst |=> $stable(p_q.min_lvl) && $stable(p_q.err_cnt))
        else $error("tracking fields moved with reserved select");

    err_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        p_q.en && sel_ok && !p_q.trk_rst && sel_err && (p_q.err_cnt != `ADFM_ERR_MAX)
        |=> p_q.err_cnt == $past(p_q.err_cnt) + 6'h01)
        else $error("error count did not step by one");

    min_track_a: assert property (@(posedge pclk) disable iff (!presetn)
        p_q.en && sel_ok && !p_q.trk_rst && (sel_lvl < p_q.min_lvl)
        |=> p_q.min_lvl == $past(sel_lvl))
        else $error("minimum level missed a lower value");

    dma_pos_a: assert property (@(posedge pclk) disable iff (!presetn)
        eng[0].load && !eng[0].bdl_start |=>
        p_q.dma_pos[0] == $past(p_q.dma_pos[0]) + {24'h00_0000, $past(eng[0].load_bytes)})
        else $error("DMA position did not add loaded bytes");

    ring_dis_a: assert property (@(posedge pclk) disable iff (!presetn)
        p_q.rp_dis |-> !ring_ptr_reset)
        else $error("ring reset asserted while disabled");

    wclk_step_a: assert property (@(posedge link_bclk) disable iff (!presetn)
        l_q.en_s2 |=> l_q.wclk == $past(l_q.wclk) + 32'h0000_0001)
        else $error("wall clock did not advance");

    wclk_hold_a: assert property (@(posedge link_bclk) disable iff (!presetn)
        !l_q.en_s2 |=> $stable(l_q.wclk))
        else $error("wall clock advanced while disabled");

    lpos_wrap_a: assert property (@(posedge link_bclk) disable iff (!presetn)
        link_byte[0] && ((l_q.lpos[0] + 32'h0000_0001) >= l_q.cbl[0])
        |=> l_q.lpos[0] == 32'h0000_0000)
        else $error("link position did not wrap");

    alias_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
        hs_done |=> (p_q.wclk == $past(l_q.hold_wclk)) && (p_q.lpos == $past(l_q.hold_lpos)))
        else $error("alias shadow differs from link snapshot");

    pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready stood longer than one access cycle");

    min_no_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        p_q.en && sel_ok && !p_q.trk_rst |=> p_q.min_lvl <= $past(p_q.min_lvl))
        else $error("minimum level rose while tracking");

    err_no_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        !p_q.trk_rst && (p_q.err_cnt != 6'h00) |=> (p_q.err_cnt != 6'h00))
        else $error("error count wrapped to zero");

    err_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sel_err && !p_q.trk_rst |=> p_q.err_cnt == $past(p_q.err_cnt))
        else $error("error count moved without an error");

    ring_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && (paddr == `ADFM_RING_POINTER_OFS) && p_q.rp_dis
        |=> !prdata[`ADFM_RPR_BIT])
        else $error("ring reset bit read back while disabled");

    alias_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && (paddr == `ADFM_WALL_CLOCK_OFS)
        |=> prdata == $past(p_q.wclk))
        else $error("wall clock alias read differs from counter");

    lpos_step_a: assert property (@(posedge link_bclk) disable iff (!presetn)
        link_byte[1] && ((l_q.lpos[1] + 32'h0000_0001) < l_q.cbl[1])
        |=> l_q.lpos[1] == $past(l_q.lpos[1]) + 32'h0000_0001)
        else $error("link position did not count a byte");

    // Every stream restarts its position at zero with its list
    for (genvar g = 0; g < 4; g++)
    begin : g_restart
        dma_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
            eng[g].bdl_start |=> p_q.dma_pos[g] == 32'h0000_0000)
            else $error("DMA position not cleared at list restart");
    end

    err_full_c: cover property (@(posedge pclk) disable iff (!presetn)
        sel_err && (p_q.err_cnt == `ADFM_ERR_MAX) && p_q.en);
    snapshot_c: cover property (@(posedge pclk) disable iff (!presetn)
        hs_done && (l_q.hold_wclk != 32'h0000_0000));
    lpos_wrap_c: cover property (@(posedge link_bclk) disable iff (!presetn)
        link_byte[0] && (l_q.lpos[0] != 32'h0000_0000) ##1 (l_q.lpos[0] == 32'h0000_0000));
    reserved_c: cover property (@(posedge pclk) disable iff (!presetn)
        p_q.en && !sel_ok && sel_err);
    ring_block_c: cover property (@(posedge pclk) disable iff (!presetn)
        wr_acc && (paddr == `ADFM_RING_POINTER_OFS) && p_q.rp_dis);

endmodule // adfm_monitor

// ### pkg/adfm_map.svh
// Register offsets, field positions, reset values and limits of the FIFO monitor block
`ifndef ADFM_MAP_SVH
`define ADFM_MAP_SVH
`define ADFM_FIFO_TRACKING_OFS  16'h100C
`define ADFM_IN0_DMA_POS_OFS    16'h1010
`define ADFM_IN1_DMA_POS_OFS    16'h1014
`define ADFM_OUT0_DMA_POS_OFS   16'h1020
`define ADFM_OUTB_DMA_POS_OFS   16'h1024
`define ADFM_EXT_MODE_TWO_OFS   16'h1030
`define ADFM_RING_POINTER_OFS   16'h1040
`define ADFM_LINK_CTRL_OFS      16'h1044
`define ADFM_WALL_CLOCK_OFS     16'h2030
`define ADFM_IN0_LINK_POS_OFS   16'h2084
`define ADFM_IN1_LINK_POS_OFS   16'h20A4
`define ADFM_OUT0_LINK_POS_OFS  16'h2104
`define ADFM_OUTB_LINK_POS_OFS  16'h2124
`define ADFM_FIFO_TRACKING_RST  32'h000FF800
`define ADFM_MIN_HI             19
`define ADFM_MIN_LO             11
`define ADFM_ERR_HI             10
`define ADFM_ERR_LO             5
`define ADFM_SEL_HI             4
`define ADFM_SEL_LO             2
`define ADFM_EN_BIT             1
`define ADFM_RST_BIT            0
`define ADFM_MIN_DEFAULT        9'h1FF
`define ADFM_ERR_MAX            6'h3F
`define ADFM_SEL_OUT0           3'h0
`define ADFM_SEL_OUT1           3'h1
`define ADFM_SEL_IN0            3'h4
`define ADFM_SEL_IN1            3'h5
`define ADFM_RP_DIS_BIT         8
`define ADFM_RPR_BIT            15
`define ADFM_BCLK_EN_BIT        0
`endif

// ### pkg/adfm_pkg.sv
// Types shared by the FIFO monitor block
package adfm_pkg;
    // Engine index: 0 output 0, 1 output 1, 2 input 0, 3 input 1
    typedef enum logic [1:0] {
        ADFM_ENG_OUT0 = 2'b00,
        ADFM_ENG_OUT1 = 2'b01,
        ADFM_ENG_IN0  = 2'b10,
        ADFM_ENG_IN1  = 2'b11
    } adfm_eng_idx_t;

    // Status from one stream DMA engine, pclk domain
    typedef struct packed {
        logic [8:0] level;       // Free count (input) or avail count (output)
        logic       err;         // One-cycle FIFO error pulse
        logic       load;        // Bytes moved into/out of the FIFO this cycle
        logic [7:0] load_bytes;  // Byte count with load
        logic       bdl_start;   // Buffer descriptor list restarts from its head
    } adfm_eng_t;

    // All pclk-domain state
    typedef struct packed {
        logic [8:0]       min_lvl;
        logic [5:0]       err_cnt;
        logic [2:0]       sel;
        logic             en;
        logic             trk_rst;
        logic             rp_dis;
        logic             rpr;
        logic             bclk_en;
        logic [3:0][31:0] dma_pos;
        logic [31:0]      wclk;
        logic [3:0][31:0] lpos;
        logic [3:0][31:0] cbl_hold;
        logic             req;
        logic             ack_s1;
        logic             ack_s2;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } adfm_pstate_t;

    // All link-domain state
    typedef struct packed {
        logic [31:0]      wclk;
        logic [3:0][31:0] lpos;
        logic [31:0]      hold_wclk;
        logic [3:0][31:0] hold_lpos;
        logic [3:0][31:0] cbl;        // Lengths taken with the last request
        logic             req_s1;
        logic             req_s2;
        logic             ack;
        logic             en_s1;
        logic             en_s2;
    } adfm_lstate_t;
endpackage

// ### sim/adfm_far_model.sv
// Far-side model: stream DMA engines and codec link feeding the monitor
`timescale 1ns/1ps

module adfm_far_model (
    input  wire logic                  pclk,
    input  wire logic                  link_bclk,
    output adfm_pkg::adfm_eng_t [3:0]  eng,
    output logic [3:0][31:0]           cbl,
    output logic [3:0]                 link_byte
);
    import adfm_pkg::*;

    // Idle engines report a full level so they never lower the minimum
    initial
    begin
        eng = '0;
        for (int i = 0; i < 4; i++)
            eng[i].level = 9'h1FF;
        cbl = {32'h6, 32'h5, 32'h4, 32'h3};  // Stream i wraps at length i+3
        link_byte = '0;
    end

    // Hold a level through n error pulses with a gap between, then restore the full level
    task automatic fifo_event(input int i, input logic [8:0] lvl, input int n);
        @(posedge pclk);
        eng[i].level <= lvl;
        repeat (n)
        begin
            @(posedge pclk);
            eng[i].err <= 1'b1;
            @(posedge pclk);
            eng[i].err <= 1'b0;
        end
        @(posedge pclk);
        eng[i].level <= 9'h1FF;
    endtask

    // One load beat, or a list restart on its own
    task automatic dma_beat(input int i, input logic [7:0] nb, input logic st);
        @(posedge pclk);
        eng[i].load <= ~st;
        eng[i].load_bytes <= nb;
        eng[i].bdl_start <= st;
        @(posedge pclk);
        eng[i].load <= 1'b0;
        eng[i].bdl_start <= 1'b0;
        eng[i].load_bytes <= ~nb;  // Stale count must not be reused
    endtask

    // Received bytes arrive as one-cycle pulses in the link domain
    task automatic link_rx(input int i, input int n);
        repeat (n)
        begin
            @(posedge link_bclk);
            link_byte[i] <= 1'b1;
            @(posedge link_bclk);
            link_byte[i] <= 1'b0;
        end
    endtask
endmodule // adfm_far_model

// ### sim/testbench.sv
// Self-checking bench for the FIFO monitor register block
`timescale 1ns/1ps

module testbench;
    import adfm_pkg::*;

    logic              pclk, presetn, psel, penable, pwrite, link_bclk;
    logic [15:0]       paddr;
    logic [31:0]       pwdata, prdata, rd_last;
    logic              pready, pslverr, ring_ptr_reset, bclk_enable;
    logic [7:0]        ring_rd_ptr;
    adfm_eng_t [3:0]   eng;
    logic [3:0][31:0]  cbl;
    logic [3:0]        link_byte;
    logic [32:0]       exp_q[$], msk_q[$];
    integer            seed = 17;
    int                n_mismatch = 0, total_checks = 0;
    logic [15:0]       dma_ofs [4] = '{16'h1020, 16'h1024, 16'h1010, 16'h1014};
    logic [15:0]       lnk_ofs [4] = '{16'h2104, 16'h2124, 16'h2084, 16'h20A4};

    // Bus clock, and a link bit clock unrelated in phase
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        link_bclk = 1'b0;
        #7;
        forever #40 link_bclk = ~link_bclk;
    end

    adfm_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eng(eng), .cbl(cbl), .ring_rd_ptr(ring_rd_ptr),
        .ring_ptr_reset(ring_ptr_reset), .bclk_enable(bclk_enable),
        .link_bclk(link_bclk), .link_byte(link_byte));

    adfm_far_model far (.pclk(pclk), .link_bclk(link_bclk), .eng(eng), .cbl(cbl),
        .link_byte(link_byte));

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        total_checks++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // One APB transfer; its expectation is queued before the bus moves
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Hold the request until ready is seen at a rising edge; the watchdog ends a hang
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd_last = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e}, '1);
    endtask

    // Each completed transfer retires the oldest queued expectation
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(33'h0, 33'h1);
            else
                check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
        end
    end

    task automatic finish_test();
        if (exp_q.size() != 0)
            n_mismatch++;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog: the sequence needs well under 8000 bus cycles
    initial
    begin
        #200000;
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        logic [2:0]  code;
        logic [8:0]  lvl;
        logic [31:0] sum;
        logic [7:0]  nb;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        ring_rd_ptr = 8'($random(seed));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(16'h100C, 32'h000FF800);
        for (int k = 0; k < 4; k++)
        begin
            rd(dma_ofs[k], 32'h0);
            rd(lnk_ofs[k], 32'h0);
        end
        rd(16'h2030, 32'h0);
        apb(1'b0, 16'h0FFC, 32'h0, {1'b1, 32'h0}, '1);
        $display("test reset done");
        // Each valid select tracks its own engine; the neighbour is ignored
        for (int k = 0; k < 4; k++)
        begin
            code = {k[1], 1'b0, k[0]};
            lvl = 9'h080 | {1'b0, 8'($random(seed))};
            wr(16'h100C, {27'h0, code, 2'b11});
            wr(16'h100C, {27'h0, code, 2'b10});
            far.fifo_event(k ^ 1, 9'h010, 2);
            far.fifo_event(k, lvl, 1);
            rd(16'h100C, {12'h0, lvl, 6'h01, code, 2'b10});
        end
        wr(16'h100C, 32'h0000000A);
        far.fifo_event(0, 9'h001, 3);
        rd(16'h100C, {12'h0, lvl, 6'h01, 5'b01010});
        wr(16'h100C, 32'h00000000);
        far.fifo_event(0, 9'h001, 3);
        rd(16'h100C, {12'h0, lvl, 6'h01, 5'b00000});
        wr(16'h100C, 32'h00000002);
        far.fifo_event(0, 9'h1FF, 70);
        rd(16'h100C, {12'h0, lvl, 6'h3F, 5'b00010});
        wr(16'h100C, 32'h00000003);
        far.fifo_event(0, 9'h001, 2);
        rd(16'h100C, {12'h0, 9'h1FF, 6'h00, 5'b00011});
        wr(16'h100C, 32'h00000002);
        $display("test tracking done");
        for (int k = 0; k < 4; k++)
        begin
            far.dma_beat(k, 8'h55, 1'b0);
            far.dma_beat(k, 8'h00, 1'b1);
            sum = 32'h0;
            repeat (3)
            begin
                nb = 8'($random(seed));
                sum = sum + {24'h0, nb};
                far.dma_beat(k, nb, 1'b0);
            end
            wr(dma_ofs[k], 32'hFFFFFFFF);
            rd(dma_ofs[k], sum);
        end
        $display("test dma position done");
        wr(16'h1040, 32'h00008000);
        rd(16'h1040, {16'h0, 8'h80, ring_rd_ptr});
        check({32'h0, ring_ptr_reset}, 33'h1);
        wr(16'h1030, 32'h00000100);
        rd(16'h1030, 32'h00000100);
        wr(16'h1040, 32'h00008000);
        rd(16'h1040, {24'h0, ring_rd_ptr});
        check({32'h0, ring_ptr_reset}, 33'h0);
        wr(16'h1030, 32'h0);
        $display("test ring disable done");
        repeat (40) @(posedge link_bclk);
        rd(16'h2030, 32'h0);
        wr(16'h1044, 32'h1);
        @(posedge pclk);
        check({32'h0, bclk_enable}, 33'h1);
        repeat (100) @(posedge link_bclk);
        apb(1'b0, 16'h2030, 32'h0, 33'h0, 33'h1_0000_0000);
        check({32'h0, rd_last >= 85 && rd_last <= 101}, 33'h1);
        // A reset in mid-run must clear the running wall clock and its enable
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge link_bclk);
        rd(16'h2030, 32'h0);
        check({32'h0, bclk_enable}, 33'h0);
        $display("test wall clock done");
        for (int k = 0; k < 4; k++)
            far.link_rx(k, 7);
        repeat (10) @(posedge link_bclk);
        for (int k = 0; k < 4; k++)
            rd(lnk_ofs[k], 32'(7 % (k + 3)));
        $display("test link position done");
        repeat (2) @(posedge pclk);
        finish_test();
    end
endmodule // testbench
